// ### src/piap_pkg.sv
// Package with constants and types for the parallel I/O attention and paging block
package piap_pkg;
	// Address and data widths
	localparam int ADDR_W = 17;
	localparam int DATA_W = 16;
	// Page boundaries in internal address space
	localparam logic [16:0] LOW_PAGE_FIRST = 17'h00000;
	localparam logic [16:0] LOW_PAGE_LAST = 17'h0ffff;
	localparam logic [16:0] UP_PAGE_FIRST = 17'h10000;
	localparam logic [16:0] UP_PAGE_LAST = 17'h1ffff;
	// Default parallel region: 56K storage ends below 8K register space
	localparam logic [16:0] DEF_STORE_LAST = 17'h0dfff;
	localparam logic [16:0] DEF_REGS_FIRST = 17'h0e000;
	localparam logic [16:0] DEF_REGS_LAST = 17'h0ffff;
	// Parallel control register fields
	localparam int CTL_LOW_DMA_BIT = 15;
	localparam int CTL_NPR_MASK_BIT = 0;
	localparam int CTL_BR_MASK_BIT = 1;
	localparam logic [15:0] CTL_RESET = 16'h0000;
	// Interrupt priority levels
	localparam logic [2:0] HOST_CMD_LEVEL = 3'h4;
	localparam logic [2:0] HANDLER_MAX_LEVEL = 3'h3;
	localparam logic [2:0] IDLE_LEVEL_MAX = 3'h7;
	// Logical device selectors
	localparam logic [2:0] DEV_WHOLE_UNIT = 3'h0;
	localparam logic [2:0] DEV_PARALLEL = 3'h4;
	// Attention sequencer states, one-hot
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_SAVE = 7'h02,
		ST_MASK = 7'h04,
		ST_VECT = 7'h08,
		ST_ATTN = 7'h10,
		ST_WAIT = 7'h20,
		ST_USER = 7'h40
	} piap_state_e;
endpackage

// ### src/piap_map_if.sv
// Interface carrying one storage access between the sequencer and the page mapper
`timescale 1ns/1ns
interface piap_map_if;
	logic [16:0] addr; // Internal address
	logic [2:0] dev; // Logical device making the access
	logic dma; // Access comes from peripheral DMA
	logic req; // Access request
	logic ok; // Access allowed
	logic page_up; // Selected page is the upper page
	// Requester side
	modport req_mp (output addr, dev, dma, req, input ok, page_up);
	// Mapper side
	modport map_mp (input addr, dev, dma, req, output ok, page_up);
endinterface

// ### src/piap_page_map.sv
// Page mapper deciding which page an access hits and whether it is allowed
`timescale 1ns/1ns
module piap_page_map
(
	piap_map_if.map_mp m, // Access to check
	input wire logic ext_mode_i, // Extended 120K mode
	input wire logic low_dma_i // Control bit allowing DMA into lower page
);
	import piap_pkg::*;
	// Decode page and rights
	always_comb
	begin
		logic upper;
		upper = 1'b0;
		upper = (m.addr >= UP_PAGE_FIRST);
		m.page_up = upper;
		if (!m.req)
		begin
			// No access
			m.ok = 1'b0;
		end
		else if (!ext_mode_i)
		begin
			// Default: 56K storage plus 8K register space only
			m.ok = !upper;
		end
		else if (m.dma)
		begin
			// DMA into lower page only with the control bit set
			m.ok = upper || low_dma_i;
		end
		else if (m.dev == DEV_WHOLE_UNIT)
		begin
			// Whole-unit device reaches both pages
			m.ok = 1'b1;
		end
		else
		begin
			// Parallel device reaches the upper page only
			m.ok = upper && (m.dev == DEV_PARALLEL);
		end
	end
endmodule // piap_page_map

// ### src/piap_sync2.sv
// Two-flop synchroniser for a pin level
`timescale 1ns/1ns
module piap_sync2
(
	input wire logic mclk_i, // System clock
	input wire logic rst_i, // Synchronous reset
	input wire logic d_i, // Asynchronous level
	output logic q_o // Synchronised level
);
	logic s1_reg; // First stage, read only by second
	logic s2_reg; // Second stage
	// Two flip-flop chain
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
		end
		else
		begin
			s1_reg <= d_i;
			s2_reg <= s1_reg;
		end
	end
	assign q_o = s2_reg;
endmodule // piap_sync2

// ### src/piap_top.sv
// Parallel I/O interrupt to host attention sequencer with extended page mapping
`timescale 1ns/1ns
// Functional notes
// - Default: 56K storage plus 8K registers
// - Extended mode disables the serial facility
// - Extended: 00000-0FFFF maps to lower page
// - Extended: 10000-1FFFF maps to upper page
// - Whole-unit both pages; parallel device upper only
// - Lower-page DMA only with control bit 15
// - No interrupt taken during level-4 host work
// - Handling limits acceptance to levels 0-3
// - User handler invoked, then activity resumes
// - Default: save, mask, vector, attention, resume
// - Position-read restores saved control register
// - Unacknowledged attention: no more, report error
// - Position-read clears attention-pending state
// - Masked: hold request mask bits set
module piap_top
(
	input wire logic mclk_i, // System clock, 100 MHz
	input wire logic rst_i, // Synchronous reset, active high
	input wire logic periph_irq_i, // Peripheral interrupt pin, async
	input wire logic irq_enable_i, // Interrupt enable from host or code
	input wire logic host_cmd_busy_i, // Processing host commands at level 4
	input wire logic user_handler_i, // User handler entry installed
	input wire logic user_done_i, // User handler returned, one-cycle pulse
	input wire logic position_read_ack_cmd_i, // Host position-read, one-cycle pulse
	input wire logic [15:0] parallel_status_reg_i, // Parallel status register value
	input wire logic ctl_wr_i, // Write to parallel control register
	input wire logic [15:0] ctl_wdata_i, // Control register write data
	input wire logic [15:0] vector_i, // Interrupt vector from the bus
	input wire logic ext_mode_i, // Extended 120K mode select
	input wire logic acc_req_i, // Storage access request
	input wire logic [piap_pkg::ADDR_W-1:0] acc_addr_i, // Storage access address
	input wire logic [2:0] acc_dev_i, // Logical device of access
	input wire logic acc_dma_i, // Access is peripheral DMA
	output logic acc_ok_o, // Access allowed, registered
	output logic acc_page_up_o, // Access hit upper page, registered
	output logic [15:0] parallel_control_reg_o, // Parallel control register
	output logic nonprocessor_request_mask_o, // Non-processor requests masked
	output logic peripheral_bus_request_mask_o, // Bus requests masked
	output logic [15:0] vector_o, // Last vector read
	output logic attention_o, // Attention to host, one-cycle pulse
	output logic attn_pending_o, // Attention awaiting acknowledgement
	output logic attn_error_o, // Attention refused while pending, sticky
	output logic user_call_o, // Call user handler, one-cycle pulse
	output logic [2:0] accept_level_o, // Highest level that may interrupt
	output logic serial_avail_o // Serial facility usable
);
	import piap_pkg::*;

	// Whole block state
	typedef struct packed {
		piap_state_e st; // Sequencer state
		logic [15:0] ctl; // Parallel control register
		logic [15:0] saved; // Copy used for restore
		logic [15:0] vect; // Vector read
		logic attn; // Attention pulse
		logic pend; // Attention pending
		logic err; // Error flag
		logic ucall; // User call pulse
		logic [2:0] lvl; // Acceptance level
		logic ok; // Access allowed
		logic up; // Upper page hit
		logic ser; // Serial available
		logic irq_q; // Synchronised pin one cycle ago
	} piap_state_s;

	piap_state_s state_reg; // Registered state
	piap_state_s state_next; // Next state
	logic irq_sync; // Synchronised interrupt pin
	logic masked; // Interrupts currently masked
	logic irq_rise; // Fresh interrupt edge, not the level of one already served

	piap_map_if map_bus(); // Access check channel

	// Interrupt pin synchroniser
	piap_sync2 u_sync
	(
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.d_i(periph_irq_i),
		.q_o(irq_sync)
	);

	// Access path into the page mapper
	assign map_bus.addr = acc_addr_i;
	assign map_bus.dev = acc_dev_i;
	assign map_bus.dma = acc_dma_i;
	assign map_bus.req = acc_req_i;

	// Page mapper
	piap_page_map u_map
	(
		.m(map_bus.map_mp),
		.ext_mode_i(ext_mode_i),
		.low_dma_i(state_reg.ctl[CTL_LOW_DMA_BIT])
	);

	// Sequencer masked in every state but idle and user
	assign masked = (state_reg.st != ST_IDLE) && (state_reg.st != ST_USER);
	// A held pin must not count again as a new request while pending
	assign irq_rise = irq_sync && !state_reg.irq_q;

	// Next-state logic
	always_comb
	begin
		state_next = state_reg;
		state_next.attn = 1'b0;
		state_next.ucall = 1'b0;
		state_next.ok = map_bus.ok;
		state_next.up = map_bus.page_up;
		state_next.ser = !ext_mode_i;
		state_next.irq_q = irq_sync;
		// Software writes land in the control register
		if (ctl_wr_i)
		begin
			state_next.ctl = ctl_wdata_i;
		end
		case (state_reg.st)
			ST_IDLE:
			begin
				// Take interrupt only below level 4; default path only when not pending
				if (irq_sync && irq_enable_i && !host_cmd_busy_i)
				begin
					state_next.lvl = HANDLER_MAX_LEVEL;
					if (user_handler_i)
					begin
						state_next.ucall = 1'b1;
						state_next.st = ST_USER;
					end
					else if (state_reg.pend)
					begin
						// No new attention while one is open
						state_next.err = 1'b1;
						state_next.lvl = IDLE_LEVEL_MAX;
					end
					else
					begin
						state_next.st = ST_SAVE;
					end
				end
			end
			ST_USER:
			begin
				// Resume after the user handler returns
				if (user_done_i)
				begin
					state_next.lvl = IDLE_LEVEL_MAX;
					state_next.st = ST_IDLE;
				end
			end
			ST_SAVE:
			begin
				// Save status so control can be restored
				state_next.saved = parallel_status_reg_i;
				state_next.st = ST_MASK;
			end
			ST_MASK:
			begin
				// Mask bus requests
				state_next.ctl[CTL_NPR_MASK_BIT] = 1'b1;
				state_next.ctl[CTL_BR_MASK_BIT] = 1'b1;
				state_next.st = ST_VECT;
			end
			ST_VECT:
			begin
				// Read interrupt vector
				state_next.vect = vector_i;
				state_next.st = ST_ATTN;
			end
			ST_ATTN:
			begin
				// Send the attention, then resume at lower level
				state_next.attn = 1'b1;
				state_next.pend = 1'b1;
				state_next.lvl = IDLE_LEVEL_MAX;
				state_next.st = ST_WAIT;
			end
			ST_WAIT:
			begin
				// Hold masks until acknowledgement restores control
				state_next.ctl[CTL_NPR_MASK_BIT] = 1'b1;
				state_next.ctl[CTL_BR_MASK_BIT] = 1'b1;
				if (position_read_ack_cmd_i)
				begin
					state_next.ctl = state_reg.saved;
					state_next.st = ST_IDLE;
				end
				// Only a new interrupt edge counts as refused
				else if (irq_rise && irq_enable_i && !host_cmd_busy_i)
				begin
					state_next.err = 1'b1;
				end
			end
			default:
			begin
				state_next.st = ST_IDLE;
			end
		endcase
		// Masks forced while handling from the mask state on; the restore on acknowledge is left alone
		if (masked && state_reg.st != ST_SAVE && state_next.st != ST_IDLE)
		begin
			state_next.ctl[CTL_NPR_MASK_BIT] = 1'b1;
			state_next.ctl[CTL_BR_MASK_BIT] = 1'b1;
		end
		// Any position-read clears pending and error
		if (position_read_ack_cmd_i)
		begin
			state_next.pend = 1'b0;
			state_next.err = 1'b0;
		end
	end

	// State register
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			state_reg <= '{st: ST_IDLE, ctl: CTL_RESET, saved: CTL_RESET, vect: 16'h0000,
				attn: 1'b0, pend: 1'b0, err: 1'b0, ucall: 1'b0, lvl: IDLE_LEVEL_MAX,
				ok: 1'b0, up: 1'b0, ser: 1'b1, irq_q: 1'b0};
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	// Outputs straight from flops
	assign acc_ok_o = state_reg.ok;
	assign acc_page_up_o = state_reg.up;
	assign parallel_control_reg_o = state_reg.ctl;
	assign nonprocessor_request_mask_o = state_reg.ctl[CTL_NPR_MASK_BIT];
	assign peripheral_bus_request_mask_o = state_reg.ctl[CTL_BR_MASK_BIT];
	assign vector_o = state_reg.vect;
	assign attention_o = state_reg.attn;
	assign attn_pending_o = state_reg.pend;
	assign attn_error_o = state_reg.err;
	assign user_call_o = state_reg.ucall;
	assign accept_level_o = state_reg.lvl;
	assign serial_avail_o = state_reg.ser;

	// Assertions
	no_take_busy_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(state_reg.st == ST_IDLE && host_cmd_busy_i)
		|=> state_reg.st == ST_IDLE && accept_level_o == IDLE_LEVEL_MAX)
		else $error("interrupt taken while busy");
	level_limit_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(state_reg.st inside {ST_SAVE, ST_MASK, ST_VECT, ST_USER})
		|-> accept_level_o == HANDLER_MAX_LEVEL)
		else $error("level not restricted");
	default_seq_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(state_reg.st == ST_SAVE) |=> ##3 attention_o ##1 !attention_o)
		else $error("attention sequence broken");
	restore_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(state_reg.st == ST_WAIT && position_read_ack_cmd_i && !ctl_wr_i)
		|=> parallel_control_reg_o == $past(state_reg.saved))
		else $error("control not restored");
	no_second_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		attn_pending_o && !position_read_ack_cmd_i |=> !attention_o)
		else $error("second attention sent");
	clear_pend_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		position_read_ack_cmd_i |=> !attn_pending_o)
		else $error("pending not cleared");
	mask_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		attention_o |-> nonprocessor_request_mask_o && peripheral_bus_request_mask_o)
		else $error("requests unmasked during attention");
	serial_off_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		ext_mode_i |=> !serial_avail_o)
		else $error("serial still available");
	user_call_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		user_call_o |-> state_reg.st == ST_USER)
		else $error("user call without user state");
	wait_masks_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		state_reg.st == ST_WAIT
		|-> nonprocessor_request_mask_o && peripheral_bus_request_mask_o)
		else $error("requests unmasked while waiting");
	err_flag_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(state_reg.st == ST_WAIT && irq_rise && irq_enable_i && !host_cmd_busy_i
		&& !position_read_ack_cmd_i) |=> attn_error_o)
		else $error("refused attention not reported");
	plain_range_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(acc_req_i && !ext_mode_i && acc_addr_i >= UP_PAGE_FIRST) |=> !acc_ok_o)
		else $error("access beyond default region allowed");
	low_dma_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(acc_req_i && ext_mode_i && acc_dma_i && acc_addr_i <= LOW_PAGE_LAST
		&& !parallel_control_reg_o[CTL_LOW_DMA_BIT]) |=> !acc_ok_o)
		else $error("lower page DMA without control bit");
	par_dev_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(acc_req_i && ext_mode_i && !acc_dma_i && acc_dev_i == DEV_PARALLEL
		&& acc_addr_i <= LOW_PAGE_LAST) |=> !acc_ok_o)
		else $error("parallel device reached lower page");
	cov_attn_c: cover property (@(posedge mclk_i) disable iff (rst_i)
		attention_o ##[1:20] position_read_ack_cmd_i);
	cov_user_c: cover property (@(posedge mclk_i) disable iff (rst_i)
		user_call_o ##[1:20] user_done_i);
	cov_err_c: cover property (@(posedge mclk_i) disable iff (rst_i) $rose(attn_error_o));
	cov_busy_c: cover property (@(posedge mclk_i) disable iff (rst_i)
		state_reg.st == ST_IDLE && irq_sync && host_cmd_busy_i);
	cov_low_dma_c: cover property (@(posedge mclk_i) disable iff (rst_i)
		(acc_req_i && ext_mode_i && acc_dma_i && acc_addr_i <= LOW_PAGE_LAST)
		##1 acc_ok_o);
endmodule // piap_top

// ### verification/piap_partner.sv
// Host model that acknowledges each attention with a position-read pulse
`timescale 1ns/1ns
module piap_partner
(
	input wire logic mclk_i, // System clock
	input wire logic rst_i, // Synchronous reset
	input wire logic attention_i, // Attention from the block
	input wire logic ack_en_i, // Host willing to acknowledge
	input wire logic [3:0] ack_delay_i, // Cycles before the acknowledgement
	output logic position_read_ack_cmd_o // Position-read pulse
);
	logic owed_reg; // Attention accepted, not yet acknowledged
	logic [3:0] cnt_reg; // Delay left before acknowledging
	// Every accepted attention is answered by one position-read
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			owed_reg <= 1'b0;
			cnt_reg <= 4'h0;
			position_read_ack_cmd_o <= 1'b0;
		end
		else
		begin
			position_read_ack_cmd_o <= 1'b0;
			if (attention_i)
			begin
				owed_reg <= 1'b1;
				cnt_reg <= ack_delay_i;
			end
			else if (owed_reg && ack_en_i)
			begin
				if (cnt_reg == 4'h0)
				begin
					position_read_ack_cmd_o <= 1'b1;
					owed_reg <= 1'b0;
				end
				else
					cnt_reg <= cnt_reg - 4'h1;
			end
		end
	end
endmodule // piap_partner

// ### verification/piap_top_tb.sv
// Self-checking bench for the attention sequencer and page mapper
`timescale 1ns/1ns
module piap_top_tb;
	import piap_pkg::*;
	logic mclk_i, rst_i, periph_irq_i, irq_enable_i, host_cmd_busy_i, user_handler_i;
	logic user_done_i, position_read_ack_cmd_i, ctl_wr_i, ext_mode_i, acc_req_i, acc_dma_i;
	logic [15:0] parallel_status_reg_i, ctl_wdata_i, vector_i, parallel_control_reg_o, vector_o;
	logic [16:0] acc_addr_i;
	logic [2:0] acc_dev_i, accept_level_o;
	logic acc_ok_o, acc_page_up_o, nonprocessor_request_mask_o, peripheral_bus_request_mask_o;
	logic attention_o, attn_pending_o, attn_error_o, user_call_o, serial_avail_o;
	logic ack_en, req_q, pend_q;
	logic [3:0] ack_dly;
	logic [15:0] exp_vec[$], exp_ctl[$]; // Expected vector and restored control
	logic [1:0] exp_acc[$]; // Expected {allowed, upper page}
	logic [31:0] seed = 32'hb505;
	int num_errors = 0, compares = 0, n_attn = 0, n_clr = 0, n_user = 0;
	piap_top u_piap_top (.mclk_i, .rst_i, .periph_irq_i, .irq_enable_i, .host_cmd_busy_i,
		.user_handler_i, .user_done_i, .position_read_ack_cmd_i, .parallel_status_reg_i,
		.ctl_wr_i, .ctl_wdata_i, .vector_i, .ext_mode_i, .acc_req_i, .acc_addr_i, .acc_dev_i,
		.acc_dma_i, .acc_ok_o, .acc_page_up_o, .parallel_control_reg_o,
		.nonprocessor_request_mask_o, .peripheral_bus_request_mask_o, .vector_o, .attention_o,
		.attn_pending_o, .attn_error_o, .user_call_o, .accept_level_o, .serial_avail_o);
	piap_partner u_piap_partner (.mclk_i, .rst_i, .attention_i(attention_o), .ack_en_i(ack_en),
		.ack_delay_i(ack_dly), .position_read_ack_cmd_o(position_read_ack_cmd_i));
	// Free-running 100 MHz clock
	initial
	begin
		mclk_i = 1'b0;
		forever #5 mclk_i = ~mclk_i;
	end
	// Next value of the xorshift generator
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Expected access answer worked out from the page rules
	function automatic logic [1:0] acc_exp(logic [16:0] a, logic [2:0] d, logic m, logic x,
		logic l);
		if (!x)
			return {!a[16], a[16]};
		if (m)
			return {a[16] | l, a[16]};
		return {(d == 3'h0) | a[16], a[16]};
	endfunction
	// One comparison, counted and reported
	task automatic chk(string n, logic [16:0] e, logic [16:0] s);
		compares++;
		if (s !== e)
		begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	// Verdict and end of run
	task automatic tally_and_finish();
		$display("compares %0d num_errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Bounded wait for a monitor counter to reach a target
	task automatic wait_n(ref int c, input int t);
		for (int i = 0; i < 100; i++)
		begin
			@(posedge mclk_i);
			if (c >= t)
				return;
		end
		num_errors++;
		$display("CHECK FAILED wait expected %0d seen %0d", t, c);
		tally_and_finish();
	endtask
	// Raise an interrupt, optionally held off by level-4 host work first
	task automatic fire(logic [15:0] s, logic [15:0] v, logic b);
		int t, tc;
		t = n_attn + 1;
		tc = n_clr + 1;
		parallel_status_reg_i <= s;
		vector_i <= v;
		exp_vec.push_back(v);
		exp_ctl.push_back(s);
		host_cmd_busy_i <= b;
		periph_irq_i <= 1'b1;
		if (b)
		begin
			repeat (10) @(posedge mclk_i);
			chk("attn_count", t - 1, n_attn);
			host_cmd_busy_i <= 1'b0;
		end
		wait_n(n_attn, t);
		periph_irq_i <= 1'b0;
		if (ack_en)
			wait_n(n_clr, tc);
	endtask
	// Output monitor: takes the oldest note whenever a result appears
	always @(negedge mclk_i)
	begin
		if (!rst_i)
		begin
			if (attention_o)
			begin
				n_attn++;
				chk("vector", exp_vec.pop_front(), vector_o);
			end
			if (attn_pending_o)
				chk("masks", 2'b11, {nonprocessor_request_mask_o,
					peripheral_bus_request_mask_o});
			if (pend_q && !attn_pending_o)
			begin
				n_clr++;
				chk("restored_ctl", exp_ctl.pop_front(), parallel_control_reg_o);
			end
			if (user_call_o)
			begin
				n_user++;
				chk("accept_level", HANDLER_MAX_LEVEL, accept_level_o);
			end
			if (req_q)
				chk("access", exp_acc.pop_front(), {acc_ok_o, acc_page_up_o});
		end
		pend_q = attn_pending_o;
	end
	// Request seen by the design at this edge
	always @(posedge mclk_i)
		req_q <= acc_req_i;
	// Main sequence
	initial
	begin
		{periph_irq_i, irq_enable_i, host_cmd_busy_i, user_handler_i, user_done_i} = 5'h00;
		{ctl_wr_i, ext_mode_i, acc_req_i, acc_dma_i, pend_q} = 5'h00;
		{parallel_status_reg_i, ctl_wdata_i, vector_i, acc_addr_i, acc_dev_i} = '0;
		{ack_en, ack_dly} = 5'h10;
		rst_i = 1'b1;
		repeat (4) @(posedge mclk_i);
		rst_i <= 1'b0;
		@(posedge mclk_i);
		#1;
		chk("reset_level", IDLE_LEVEL_MAX, accept_level_o);
		chk("reset_serial", 1'b1, serial_avail_o);
		irq_enable_i <= 1'b1;
		repeat (3) @(posedge mclk_i);
		// Default handling, first one held off by level-4 work
		for (int i = 0; i < 4; i++)
		begin
			ack_dly <= rnd();
			fire(rnd(), rnd(), i == 0);
		end
		// Second interrupt while unacknowledged
		ack_en <= 1'b0;
		fire(rnd(), rnd(), 1'b0);
		repeat (3) @(posedge mclk_i);
		#1;
		chk("attn_error", 1'b0, attn_error_o);
		@(posedge mclk_i);
		periph_irq_i <= 1'b1;
		repeat (8) @(posedge mclk_i);
		periph_irq_i <= 1'b0;
		#1;
		chk("attn_error", 1'b1, attn_error_o);
		chk("attn_count", 5, n_attn);
		ack_en <= 1'b1;
		wait_n(n_clr, 5);
		#1;
		chk("attn_error", 1'b0, attn_error_o);
		// User handler path
		user_handler_i <= 1'b1;
		periph_irq_i <= 1'b1;
		wait_n(n_user, 1);
		periph_irq_i <= 1'b0;
		repeat (2) @(posedge mclk_i);
		user_done_i <= 1'b1;
		@(posedge mclk_i);
		user_done_i <= 1'b0;
		repeat (2) @(posedge mclk_i);
		#1;
		chk("resume_level", IDLE_LEVEL_MAX, accept_level_o);
		user_handler_i <= 1'b0;
		// Access checks, plain mode first, then extended with DMA control varied
		for (int i = 0; i < 48; i++)
		begin
			if (i == 8)
			begin
				acc_req_i <= 1'b0;
				ext_mode_i <= 1'b1;
				repeat (2) @(posedge mclk_i);
				#1;
				chk("serial_avail", 1'b0, serial_avail_o);
			end
			if (i % 8 == 0 && i > 0)
			begin
				acc_req_i <= 1'b0;
				ctl_wr_i <= 1'b1;
				ctl_wdata_i <= {rnd() % 2 == 1, 15'h0000};
				@(posedge mclk_i);
				ctl_wr_i <= 1'b0;
				@(posedge mclk_i);
			end
			acc_addr_i <= rnd();
			acc_dma_i <= (i >= 8) & rnd() % 2 == 1;
			acc_dev_i <= (i >= 8 && rnd() % 2 == 1) ? DEV_PARALLEL : DEV_WHOLE_UNIT;
			acc_req_i <= 1'b1;
			#1;
			exp_acc.push_back(acc_exp(acc_addr_i, acc_dev_i, acc_dma_i, ext_mode_i,
				parallel_control_reg_o[CTL_LOW_DMA_BIT]));
			@(posedge mclk_i);
		end
		acc_req_i <= 1'b0;
		repeat (3) @(posedge mclk_i);
		tally_and_finish();
	end
endmodule // piap_top_tb
